// ===== logic/temp_monitor_params.svh
`ifndef TEMP_MONITOR_PARAMS_SVH
`define TEMP_MONITOR_PARAMS_SVH

// Register offsets.
`define ADDR_TEMP_UPPER     8'h00
`define ADDR_STATUS         8'h01
`define ADDR_TEMP_LOWER     8'h02
`define ADDR_CONFIG         8'h03
`define ADDR_RATE           8'h04
`define ADDR_HIGH_UPPER     8'h05
`define ADDR_HIGH_LOWER     8'h06
`define ADDR_LOW_UPPER      8'h07
`define ADDR_LOW_LOWER      8'h08
`define ADDR_ONE_SHOT       8'h0F
`define ADDR_OT_LIMIT       8'h20
`define ADDR_OT_HYST        8'h21
`define ADDR_TIMEOUT_EN     8'h22

// Reset values.
`define CONFIG_RESET        8'h00
`define RATE_RESET          8'h04
`define HIGH_UPPER_RESET    8'h55
`define LIMIT_LOWER_RESET   2'h0
`define LOW_UPPER_RESET     8'h00
`define OT_LIMIT_RESET      8'h55
`define OT_HYST_RESET       8'h0A
`define TIMEOUT_EN_RESET    8'h00

// Field positions.
`define CFG_MASK_BIT        7
`define CFG_STANDBY_BIT     6
`define CFG_ROLE_BIT        5
`define TIMEOUT_EN_BIT      7
`define STAT_BUSY_BIT       7
`define STAT_HIGH_BIT       6
`define STAT_LOW_BIT        5
`define STAT_OT_BIT         0

// Timing.
`define CLK_HZ              50000000
`define BUS_TIMEOUT_MS      25
`define RATE_MAX_CODE       4'h9
`define RATE_SLOWEST_MS     14'd16000

`endif

// ===== logic/temp_monitor_pkg.sv
package temp_monitor_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic level;
    logic oe_n;
  } od_pin_type;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_CONVERT,
    ST_IDLE
  } conv_state_type;

endpackage

// ===== logic/cycle_divider.sv
`timescale 1ns/1ns
`include "temp_monitor_params.svh"

module cycle_divider #(
  parameter int COUNT = 50000
) (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_i,    // Synchronous reset, active high
  input  wire logic run_i,    // Count while high
  input  wire logic clear_i,  // Restart the count
  output logic      tick_o    // One-cycle pulse every COUNT cycles
);

  localparam int WIDTH = $clog2(COUNT + 1);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);

  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (count == LAST) begin
      count  <= '0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end

  divider_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    clear_i |=> !tick_o) else $error("tick followed a clear");

  divider_period_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    tick_o |-> $past(count) == LAST && $past(run_i)) else $error("tick at wrong count");

endmodule

// ===== logic/hyst_compare.sv
`timescale 1ns/1ns

module hyst_compare #(
  parameter int WIDTH = 12
) (
  input  wire logic                    clk_i,     // System clock
  input  wire logic                    rst_i,     // Synchronous reset, active high
  input  wire logic                    sample_i,  // Evaluate the measurement now
  input  wire logic signed [WIDTH-1:0] value_i,   // Measured temperature
  input  wire logic signed [WIDTH-1:0] limit_i,   // Assert above this
  input  wire logic signed [WIDTH-1:0] hyst_i,    // Release distance below the limit
  output logic                         active_o   // Output asserted
);

  logic signed [WIDTH-1:0] release_level;

  // Width leaves headroom so limit minus the largest hysteresis cannot wrap.
  assign release_level = limit_i - hyst_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
    end else if (sample_i) begin
      if (value_i > limit_i) begin
        active_o <= 1'b1; // R11
      end else if (value_i < release_level) begin
        active_o <= 1'b0; // R17
      end
    end
  end

  hyst_assert_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    sample_i && value_i > limit_i |=> active_o) else $error("output not asserted above limit");

  hyst_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    active_o && !(sample_i && value_i < release_level) |=> active_o) else $error("released inside band");

  hyst_release_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    sample_i && value_i < release_level |=> !active_o) else $error("not released below band");

endmodule

// ===== logic/temp_monitor_control.sv
// Summary of operation
// R1: Configuration bit 6 clear runs conversions continuously at the programmed rate.
// R2: Configuration bit 6 set holds standby; no periodic conversions; registers stay reachable.
// R3: A one-shot write in standby runs one conversion and comparison, then standby.
// R4: A one-shot write during continuous mode is ignored.
// R5: Configuration bit 5 picks alert role or second overtemperature role; mask then ignored.
// R6: Low four rate bits set the idle delay between conversions.
// R7: Rate codes double from 1/16 to 32 per second; codes above 09h reserved.
// R8: High limit is ten bits: upper byte plus bits 7:6 of lower byte.
// R9: Low limit is built the same way from its two bytes.
// R10: Low flag when result at or below low limit; high flag when above high.
// R11: Result above the overtemperature limit asserts the unmaskable overtemperature output.
// R12: In second overtemperature role, a result above the high limit asserts it.
// R13: Hysteresis resets to 10 degrees, writable anytime, sets overtemperature release.
// R14: Second overtemperature role also releases at high limit minus hysteresis.
// R15: Timeout enable bit 7 turns bus timeout on; resets to zero.
// R16: Enabled timeout abandons a transaction after about 25 ms bus inactivity.
// R17: Overtemperature outputs hold until temperature falls below limit minus hysteresis.
// R18: Configuration bit 7 masks the shared output in alert role.
// R19: Status read clears each flag only if its condition no longer holds.
// R20: Alert latches until alert response answered and status flags are cleared.
// R21: Comparisons and status updates happen once at each conversion end; limit register writes also trigger a comparison.
// R22: Busy is high only during a conversion.
`timescale 1ns/1ns
`include "temp_monitor_params.svh"

module temp_monitor_control #(
  parameter int MS_CYCLES      = `CLK_HZ / 1000,
  parameter int TIMEOUT_CYCLES = `BUS_TIMEOUT_MS * (`CLK_HZ / 1000)
) (
  input  wire logic                         clk_i,           // System clock, 50 MHz
  input  wire logic                         rst_i,           // Synchronous reset, active high
  input  wire temp_monitor_pkg::reg_req_type reg_req_i,      // Register access from the bus engine
  output logic [7:0]                        reg_rdata_o,     // Read data, one cycle after rd
  output logic                              conv_start_o,    // Start one conversion
  input  wire logic                         conv_done_i,     // Conversion finished
  input  wire logic [9:0]                   conv_result_i,   // Result, valid with conv_done_i
  input  wire logic                         ara_ack_i,       // Alert response answered
  input  wire logic                         bus_activity_i,  // Bus activity seen
  output logic                              bus_timeout_o,   // Abandon the transaction
  output temp_monitor_pkg::od_pin_type      overtemp_pin_o,  // Overtemperature open-drain pin
  output temp_monitor_pkg::od_pin_type      shared_pin_o     // Alert or second overtemperature pin
);

  default clocking cb @(posedge clk_i);
  endclocking

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [7:0]  config_reg;
  logic [7:0]  conversion_rate;
  logic [7:0]  high_limit_upper;
  logic [1:0]  high_limit_lower;
  logic [7:0]  low_limit_upper;
  logic [1:0]  low_limit_lower;
  logic [7:0]  overtemp_limit;
  logic [7:0]  overtemp_hysteresis;
  logic [7:0]  bus_timeout_enable;
  logic [9:0]  temp_value;
  logic [1:0]  temp_lower_hold;
  logic        cmp_now;
  logic        high_limit_flag;
  logic        low_limit_flag;
  logic        overtemp_flag;
  logic        alert_latched;
  logic        overtemp_active;
  logic        second_overtemp_active;
  logic        ms_tick;
  logic        timeout_tick;
  logic [13:0] idle_ms;
  logic [13:0] idle_target;
  logic [3:0]  rate_code;
  logic        idle_done;
  logic        cfg_standby;
  logic        cfg_role;
  logic        cfg_mask;
  logic        busy;
  logic        start_now;
  logic        wr_oneshot;
  logic        wr_limit;
  logic        rd_status;
  logic        high_cond;
  logic        low_cond;
  logic [7:0]  status_byte;

  logic signed [11:0] temp_s;
  logic signed [11:0] high_s;
  logic signed [11:0] low_s;
  logic signed [11:0] ot_limit_s;
  logic signed [11:0] hyst_s;

  temp_monitor_pkg::conv_state_type state;
  temp_monitor_pkg::conv_state_type next_state;

  assign cfg_standby = config_reg[`CFG_STANDBY_BIT];
  assign cfg_role    = config_reg[`CFG_ROLE_BIT];
  assign cfg_mask    = config_reg[`CFG_MASK_BIT];
  assign wr_oneshot  = reg_req_i.wr && reg_req_i.addr == `ADDR_ONE_SHOT;
  assign rd_status   = reg_req_i.rd && reg_req_i.addr == `ADDR_STATUS;
  assign wr_limit    = reg_req_i.wr && (reg_req_i.addr == `ADDR_HIGH_UPPER || reg_req_i.addr == `ADDR_HIGH_LOWER ||
                       reg_req_i.addr == `ADDR_LOW_UPPER || reg_req_i.addr == `ADDR_LOW_LOWER ||
                       reg_req_i.addr == `ADDR_OT_LIMIT || reg_req_i.addr == `ADDR_OT_HYST);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg          <= `CONFIG_RESET;
      conversion_rate     <= `RATE_RESET;
      high_limit_upper    <= `HIGH_UPPER_RESET;
      high_limit_lower    <= `LIMIT_LOWER_RESET;
      low_limit_upper     <= `LOW_UPPER_RESET;
      low_limit_lower     <= `LIMIT_LOWER_RESET;
      overtemp_limit      <= `OT_LIMIT_RESET;
      overtemp_hysteresis <= `OT_HYST_RESET; // R13
      bus_timeout_enable  <= `TIMEOUT_EN_RESET; // R15
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `ADDR_CONFIG:      config_reg          <= reg_req_i.wdata;
        `ADDR_RATE:        conversion_rate     <= reg_req_i.wdata;
        `ADDR_HIGH_UPPER:  high_limit_upper    <= reg_req_i.wdata; // R8
        `ADDR_HIGH_LOWER:  high_limit_lower    <= reg_req_i.wdata[7:6]; // R8
        `ADDR_LOW_UPPER:   low_limit_upper     <= reg_req_i.wdata; // R9
        `ADDR_LOW_LOWER:   low_limit_lower     <= reg_req_i.wdata[7:6]; // R9
        `ADDR_OT_LIMIT:    overtemp_limit      <= reg_req_i.wdata;
        `ADDR_OT_HYST:     overtemp_hysteresis <= reg_req_i.wdata; // R13
        `ADDR_TIMEOUT_EN:  bus_timeout_enable  <= reg_req_i.wdata; // R15
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.

  // Reserved rate codes run at the fastest defined rate rather than stalling.
  assign rate_code   = (conversion_rate[3:0] > `RATE_MAX_CODE) ? `RATE_MAX_CODE : conversion_rate[3:0]; // R7
  assign idle_target = `RATE_SLOWEST_MS >> rate_code; // R6 R7
  assign idle_done   = idle_ms >= idle_target;
  assign busy        = state == temp_monitor_pkg::ST_CONVERT; // R22

  always_comb begin
    next_state = state;
    start_now  = 1'b0;
    unique case (state)
      temp_monitor_pkg::ST_STANDBY: begin
        if (!cfg_standby || wr_oneshot) begin // R1 R3
          next_state = temp_monitor_pkg::ST_CONVERT;
          start_now  = 1'b1;
        end
      end
      temp_monitor_pkg::ST_CONVERT: begin
        if (conv_done_i) begin
          next_state = cfg_standby ? temp_monitor_pkg::ST_STANDBY : temp_monitor_pkg::ST_IDLE; // R3
        end
      end
      temp_monitor_pkg::ST_IDLE: begin // R4
        if (cfg_standby) begin
          next_state = temp_monitor_pkg::ST_STANDBY; // R2
        end else if (idle_done) begin
          next_state = temp_monitor_pkg::ST_CONVERT; // R1
          start_now  = 1'b1;
        end
      end
      default: next_state = temp_monitor_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= temp_monitor_pkg::ST_STANDBY;
      conv_start_o <= 1'b0;
    end else begin
      state        <= next_state;
      conv_start_o <= start_now;
    end
  end

  // The first millisecond after entering idle may be partial; rate error stays under 1 ms.
  always_ff @(posedge clk_i) begin
    if (rst_i || state != temp_monitor_pkg::ST_IDLE) begin
      idle_ms <= 14'd0;
    end else if (ms_tick && !idle_done) begin
      idle_ms <= idle_ms + 14'd1; // R6
    end
  end

  cycle_divider #(
    .COUNT (MS_CYCLES)
  ) u_ms_divider (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (1'b1),
    .clear_i (1'b0),
    .tick_o  (ms_tick)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Measurement capture and limit comparison.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_value <= 10'h000;
      cmp_now    <= 1'b0;
    end else begin
      if (busy && conv_done_i) begin
        temp_value <= conv_result_i;
      end
      // Limit writes re-test the stored result so that new limits act in standby too.
      cmp_now <= (busy && conv_done_i) || wr_limit; // R21
    end
  end

  assign temp_s     = {{2{temp_value[9]}}, temp_value};
  assign high_s     = {{2{high_limit_upper[7]}}, high_limit_upper, high_limit_lower}; // R8
  assign low_s      = {{2{low_limit_upper[7]}}, low_limit_upper, low_limit_lower}; // R9
  assign ot_limit_s = {{2{overtemp_limit[7]}}, overtemp_limit, 2'b00};
  assign hyst_s     = {2'b00, overtemp_hysteresis, 2'b00};
  assign high_cond  = temp_s > high_s; // R10
  assign low_cond   = temp_s <= low_s; // R10

  hyst_compare #(
    .WIDTH (12)
  ) u_overtemp_cmp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (cmp_now),
    .value_i  (temp_s),
    .limit_i  (ot_limit_s),
    .hyst_i   (hyst_s),
    .active_o (overtemp_active)
  );

  hyst_compare #(
    .WIDTH (12)
  ) u_second_overtemp_cmp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (cmp_now),
    .value_i  (temp_s),
    .limit_i  (high_s),
    .hyst_i   (hyst_s),
    .active_o (second_overtemp_active)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Status flags and alert latch. A set in the cycle of a clearing read wins.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_limit_flag <= 1'b0;
      low_limit_flag  <= 1'b0;
      overtemp_flag   <= 1'b0;
    end else begin
      high_limit_flag <= (cmp_now && high_cond) || (high_limit_flag && !(rd_status && !high_cond)); // R10 R19
      low_limit_flag  <= (cmp_now && low_cond) || (low_limit_flag && !(rd_status && !low_cond)); // R10 R19
      overtemp_flag   <= overtemp_active || (overtemp_flag && !rd_status); // R19
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_latched <= 1'b0;
    end else begin
      alert_latched <= (cmp_now && (high_cond || low_cond) && !cfg_role) ||
                       (alert_latched && !(ara_ack_i && !high_limit_flag && !low_limit_flag)); // R20
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pins and bus timeout. The pins only ever pull low; the level bit stays zero.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overtemp_pin_o <= '{level: 1'b0, oe_n: 1'b1};
      shared_pin_o   <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      overtemp_pin_o <= '{level: 1'b0, oe_n: !overtemp_active}; // R11
      shared_pin_o   <= '{level: 1'b0, oe_n: cfg_role ? !second_overtemp_active : // R5 R12 R14
                                                 !(alert_latched && !cfg_mask)}; // R18
    end
  end

  cycle_divider #(
    .COUNT (TIMEOUT_CYCLES)
  ) u_timeout_divider (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (bus_timeout_enable[`TIMEOUT_EN_BIT]), // R15
    .clear_i (bus_activity_i),
    .tick_o  (timeout_tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_timeout_o <= 1'b0;
    end else begin
      bus_timeout_o <= timeout_tick; // R16
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Read path. The temperature lower byte is frozen by a read of the upper byte.

  always_comb begin
    status_byte                 = 8'h00;
    status_byte[`STAT_BUSY_BIT] = busy; // R22
    status_byte[`STAT_HIGH_BIT] = high_limit_flag;
    status_byte[`STAT_LOW_BIT]  = low_limit_flag;
    status_byte[`STAT_OT_BIT]   = overtemp_flag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_lower_hold <= 2'h0;
    end else if (reg_req_i.rd && reg_req_i.addr == `ADDR_TEMP_UPPER) begin
      temp_lower_hold <= temp_value[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `ADDR_TEMP_UPPER:  reg_rdata_o <= temp_value[9:2];
        `ADDR_STATUS:      reg_rdata_o <= status_byte;
        `ADDR_TEMP_LOWER:  reg_rdata_o <= {temp_lower_hold, 6'h00};
        `ADDR_CONFIG:      reg_rdata_o <= config_reg;
        `ADDR_RATE:        reg_rdata_o <= conversion_rate;
        `ADDR_HIGH_UPPER:  reg_rdata_o <= high_limit_upper;
        `ADDR_HIGH_LOWER:  reg_rdata_o <= {high_limit_lower, 6'h00}; // R8
        `ADDR_LOW_UPPER:   reg_rdata_o <= low_limit_upper;
        `ADDR_LOW_LOWER:   reg_rdata_o <= {low_limit_lower, 6'h00}; // R9
        `ADDR_OT_LIMIT:    reg_rdata_o <= overtemp_limit;
        `ADDR_OT_HYST:     reg_rdata_o <= overtemp_hysteresis;
        `ADDR_TIMEOUT_EN:  reg_rdata_o <= bus_timeout_enable;
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence oneshot_req;
    state == temp_monitor_pkg::ST_STANDBY && cfg_standby && wr_oneshot;
  endsequence

  sequence conv_finish;
    busy && conv_done_i;
  endsequence

  oneshot_start_a: assert property (disable iff (rst_i) // R3
    oneshot_req |=> conv_start_o && busy) else $error("one-shot did not start a conversion");

  standby_return_a: assert property (disable iff (rst_i) // R3
    conv_finish ##0 cfg_standby |=> state == temp_monitor_pkg::ST_STANDBY && cmp_now)
    else $error("no return to standby with comparison");

  standby_quiet_a: assert property (disable iff (rst_i) // R2
    state == temp_monitor_pkg::ST_STANDBY && cfg_standby && !wr_oneshot |=> !conv_start_o)
    else $error("conversion started in standby");

  oneshot_ignore_a: assert property (disable iff (rst_i) // R4
    wr_oneshot && !cfg_standby && state == temp_monitor_pkg::ST_IDLE && !idle_done
    |=> state == temp_monitor_pkg::ST_IDLE && !conv_start_o) else $error("one-shot acted in run mode");

  idle_restart_a: assert property (disable iff (rst_i) // R1
    state == temp_monitor_pkg::ST_IDLE && idle_done && !cfg_standby |=> conv_start_o && busy)
    else $error("continuous mode did not restart");

  conv_busy_a: assert property (disable iff (rst_i) // R22
    conv_finish |=> !busy) else $error("busy after conversion end");

  high_flag_a: assert property (disable iff (rst_i) // R10
    conv_finish ##1 high_cond |=> high_limit_flag) else $error("high flag not set");

  low_flag_a: assert property (disable iff (rst_i) // R10
    cmp_now && low_cond |=> low_limit_flag) else $error("low flag not set");

  status_hold_a: assert property (disable iff (rst_i) // R19
    rd_status && high_limit_flag && high_cond |=> high_limit_flag) else $error("flag cleared while active");

  alert_mask_a: assert property (disable iff (rst_i) // R18
    !cfg_role && cfg_mask |=> shared_pin_o.oe_n) else $error("masked alert driven");

  role_select_a: assert property (disable iff (rst_i) // R5
    cfg_role |=> shared_pin_o.oe_n == !$past(second_overtemp_active)) else $error("second role wrong");

  hyst_reset_a: assert property ( // R13
    rst_i |=> overtemp_hysteresis == `OT_HYST_RESET) else $error("hysteresis reset value wrong");

endmodule

// ===== test/conv_model.sv
`timescale 1ns/1ns
module conv_model (
  input  wire logic       clk_i,     // System clock
  input  wire logic       start_i,   // Start one conversion
  input  wire logic [9:0] value_i,   // Value to report
  input  wire logic [7:0] delay_i,   // Conversion length in cycles
  output logic            done_o,    // Conversion finished
  output logic [9:0]      result_o   // Result, valid with done_o
);
  int cnt = 0;
  initial begin
    done_o = 1'b0;
    result_o = 10'h000;
  end
  // Outside the done cycle the result toggles, so a stale value never looks valid.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    result_o <= ~result_o;
    if (start_i) begin
      cnt <= delay_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (!start_i && cnt == 1) begin
      done_o <= 1'b1;
      result_o <= value_i;
    end
  end
endmodule

// ===== test/test_temp_monitor_control.sv
`timescale 1ns/1ns
module test_temp_monitor_control;
  logic                          clk_i = 1'b0;
  logic                          rst_i = 1'b1;
  temp_monitor_pkg::reg_req_type req = '0;
  temp_monitor_pkg::od_pin_type  ot, sh;
  logic [7:0]                    rdata, r;
  logic                          cstart, cdone, tmo;
  logic                          alert_response_addr = 1'b0;
  logic                          act = 1'b1;
  logic [9:0]                    cres;
  logic [9:0]                    value = 10'h000;
  logic [7:0]                    delay = 8'h08;
  logic [7:0]                    ra [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h21, 8'h22, 8'h10};
  logic [7:0]                    rv [10] = '{8'h00, 8'h04, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55, 8'h0A, 8'h00, 8'h00};
  int                            num_errors = 0;
  int                            n_compared = 0;
  int                            starts = 0;
  int                            tmos = 0;
  int                            s, p9, p8, pf;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (cstart === 1'b1) starts <= starts + 1;
    if (tmo === 1'b1) tmos <= tmos + 1;
  end
  // Short ms and timeout counts keep the run brief; expectations use these figures.
  temp_monitor_control #(.MS_CYCLES(4), .TIMEOUT_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .conv_start_o(cstart), .conv_done_i(cdone),
    .conv_result_i(cres), .ara_ack_i(alert_response_addr), .bus_activity_i(act), .bus_timeout_o(tmo),
    .overtemp_pin_o(ot), .shared_pin_o(sh));
  conv_model model (.clk_i(clk_i), .start_i(cstart), .value_i(value), .delay_i(delay),
    .done_o(cdone), .result_o(cres));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    req <= '0;
    cycles(1);
    r = rdata;
  endtask
  task automatic oneshot(input logic [9:0] v);
    value = v;
    wr(8'h0F, 8'h00);
    cycles(30);
  endtask
  task automatic period(output int p);
    s = starts;
    while (starts == s) @(posedge clk_i);
    s = starts;
    p = 0;
    while (starts == s) begin
      @(posedge clk_i);
      p++;
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      check("reset value", r, rv[i]);
    end
    wr(8'h04, 8'h09);
    period(p9);
    period(p9);
    wr(8'h04, 8'h08);
    period(p8);
    period(p8);
    period(p8);
    wr(8'h04, 8'h0F);
    period(pf);
    period(pf);
    period(pf);
    check("rate step", 8'(p8 - p9 > 119 && p8 - p9 < 129), 8'h01);
    check("reserved rate", 8'(pf - p9), 8'h00);
    cycles(20);
    wr(8'h0F, 8'h00);
    s = starts;
    cycles(60);
    check("run one-shot", 8'(starts - s), 8'h00);
    wr(8'h03, 8'hC0);
    cycles(40);
    s = starts;
    cycles(300);
    check("standby starts", 8'(starts - s), 8'h00);
    wr(8'h05, 8'h10);
    wr(8'h06, 8'hFF);
    rd(8'h06);
    check("high lower", r, 8'hC0);
    wr(8'h08, 8'h7F);
    rd(8'h08);
    check("low lower", r, 8'h40);
    wr(8'h20, 8'h12);
    delay = 8'h1E;
    value = 10'h050;
    s = starts;
    wr(8'h0F, 8'h00);
    rd(8'h01);
    check("busy", {7'h00, r[7]}, 8'h01);
    cycles(40);
    check("one start", 8'(starts - s), 8'h01);
    delay = 8'h08;
    rd(8'h01);
    // The low flag still stands from the cold readings taken before the limits moved.
    check("status hot", r, 8'h61);
    check("overtemp pin", {6'h00, ot}, 8'h00);
    check("masked alert", {7'h00, sh.oe_n}, 8'h01);
    wr(8'h03, 8'h40);
    cycles(4);
    check("alert", {6'h00, sh}, 8'h00);
    oneshot(10'h031);
    rd(8'h00);
    check("temp upper", r, 8'h0C);
    rd(8'h02);
    check("temp lower", r, 8'h40);
    rd(8'h01);
    check("status read", r, 8'h41);
    rd(8'h01);
    check("status cleared", r, 8'h01);
    check("alert latched", {7'h00, sh.oe_n}, 8'h00);
    @(posedge clk_i);
    alert_response_addr <= 1'b1;
    @(posedge clk_i);
    alert_response_addr <= 1'b0;
    cycles(4);
    check("alert released", {7'h00, sh.oe_n}, 8'h01);
    check("overtemp held", {7'h00, ot.oe_n}, 8'h00);
    wr(8'h03, 8'hE0);
    oneshot(10'h050);
    oneshot(10'h030);
    check("second role held", {7'h00, sh.oe_n}, 8'h00);
    oneshot(10'h010);
    check("second role off", {7'h00, sh.oe_n}, 8'h01);
    check("overtemp off", {7'h00, ot.oe_n}, 8'h01);
    oneshot(10'h000);
    rd(8'h01);
    check("low flag", {7'h00, r[5]}, 8'h01);
    wr(8'h22, 8'h80);
    rd(8'h22);
    check("timeout enable", r, 8'h80);
    @(posedge clk_i);
    act <= 1'b0;
    s = tmos;
    cycles(30);
    check("timeout", 8'(tmos - s > 0), 8'h01);
    @(posedge clk_i);
    act <= 1'b1;
    wr(8'h22, 8'h00);
    @(posedge clk_i);
    act <= 1'b0;
    s = tmos;
    cycles(60);
    check("no timeout", 8'(tmos - s), 8'h00);
    report_and_stop();
  end
endmodule
